// ---- rtl/dcw_top.sv ----
// Digital I/O direction, secondary functions and board watchdog
//
// Overview of operation
// R1: Watchdog status enable forces pin 11 output
// R2: External interrupt edge watched on pin 13
// R3: DAC load edge on pin 12 updates DACs
// R4: Converter start edge on pin 14
// R5: Converter trigger edge on pin 15
// R6: Edge select: set rising, clear falling
// R7: Group direction bit set makes outputs
// R8: Watchdog times out after written tick count
// R9: Timeout resets board as at power-on
// R10: Pin 11 held output low through reset
// R11: Timeout flag latched, survives board reset
// R12: Zero timeout value disables the watchdog
// R13: Host uses only full 32-bit accesses
// R14: Data register drives output group levels
// R15: Status write-one-clears, enables written directly
// R16: Group 0 pins 0-7, groups 1-8 single pins
// R17: Nonzero timeout write reloads the countdown
`timescale 1ns/1ps
`default_nettype none
module dcw_top
#(
  parameter int PINS   = dcw_pkg::DCW_PINS,
  parameter int GROUPS = dcw_pkg::DCW_GROUPS
)
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        adc_tick,
  input  wire logic [15:0] dio_in,
  output logic      [15:0] dio_out,
  output logic      [15:0] dio_oe,
  output logic             dac_load,
  output logic             converter_start,
  output logic             converter_trigger,
  output logic             irq_request,
  output logic             board_reset
);
  import dcw_pkg::*;

  if (PINS != DCW_PINS || GROUPS != DCW_GROUPS)
  begin
    $error("dcw_top serves only 16 pins in 9 groups");
  end

  typedef struct packed
  {
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic [31:0] ctrl;
    logic [31:0] wdt_load;
    logic [31:0] wdt_count;
    logic [15:0] dout;
    logic [7:0]  irq_en;
    logic        st_ext;
    logic        st_ldac;
    logic        st_start;
    logic        st_trig;
    logic        wdg_flag;
    logic        wdt_hold;
    logic        wdt_fire;
    logic [31:0] rdata;
    logic        rvalid;
  } dcw_state_t;

  dcw_state_t  st;
  dcw_state_t  next_st;
  logic [15:0] dir_mask;
  logic        ev_ext;
  logic        ev_ldac;
  logic        ev_start;
  logic        ev_trig;
  logic        edge_rst;

  // Direction expansion: group 0 spans a byte, the rest one pin each
  assign dir_mask = {st.ctrl[DCW_GRP_LSB +: 8], {8{st.ctrl[DCW_GRP0_BIT]}}}; // R7 R16
  // Edge logic is cleared by the watchdog too, so no stale edge survives
  assign edge_rst = rst | st.wdt_fire;

  dcw_edge u_ext
  (
    .mclk       (mclk),
    .rst        (edge_rst),
    .level      (st.sync2[DCW_PIN_EXT]),
    .enable     (st.ctrl[DCW_EXT_EN]),
    .rising_sel (st.ctrl[DCW_EXT_EDGE]),
    .pulse      (ev_ext)
  ); // R2

  dcw_edge u_ldac
  (
    .mclk       (mclk),
    .rst        (edge_rst),
    .level      (st.sync2[DCW_PIN_LDAC]),
    .enable     (st.ctrl[DCW_LDAC_EN]),
    .rising_sel (st.ctrl[DCW_LDAC_EDGE]),
    .pulse      (ev_ldac)
  ); // R3

  dcw_edge u_start
  (
    .mclk       (mclk),
    .rst        (edge_rst),
    .level      (st.sync2[DCW_PIN_START]),
    .enable     (st.ctrl[DCW_START_EN]),
    .rising_sel (st.ctrl[DCW_START_EDGE]),
    .pulse      (ev_start)
  ); // R4

  dcw_edge u_trig
  (
    .mclk       (mclk),
    .rst        (edge_rst),
    .level      (st.sync2[DCW_PIN_TRIG]),
    .enable     (st.ctrl[DCW_TRIG_EN]),
    .rising_sel (st.ctrl[DCW_TRIG_EDGE]),
    .pulse      (ev_trig)
  ); // R5

  always_comb
  begin
    next_st = st;
    next_st.sync1 = dio_in;
    next_st.sync2 = st.sync1;
    next_st.wdt_fire = 1'b0;
    next_st.rvalid = 1'b0;

    if (st.wdt_load != 32'h0000_0000 && adc_tick && !st.wdt_fire) // R12
    begin
      if (st.wdt_count <= 32'h0000_0001)
        next_st.wdt_fire = 1'b1; // R8
      else
        next_st.wdt_count = st.wdt_count - 32'h0000_0001; // R8
    end

    // Whole words only; no byte lanes exist to decode
    if (reg_wr) // R13
    begin
      unique case (reg_addr)
        DCW_OFS_CTRL: next_st.ctrl = reg_wdata & DCW_CTRL_MASK; // R1 R6 R7
        DCW_OFS_WDT:
        begin
          next_st.wdt_load = reg_wdata; // R12
          next_st.wdt_count = reg_wdata; // R17
          next_st.wdt_fire = 1'b0; // R17
        end
        DCW_OFS_DATA: next_st.dout = reg_wdata[15:0]; // R14
        DCW_OFS_IRQ:
        begin
          next_st.irq_en = reg_wdata[7:0] & DCW_IE_MASK; // R15
          if (reg_wdata[DCW_ST_EXT])   next_st.st_ext = 1'b0; // R15
          if (reg_wdata[DCW_ST_LDAC])  next_st.st_ldac = 1'b0;
          if (reg_wdata[DCW_ST_START]) next_st.st_start = 1'b0;
          if (reg_wdata[DCW_ST_TRIG])  next_st.st_trig = 1'b0;
          if (reg_wdata[DCW_ST_WDG])
          begin
            next_st.wdg_flag = 1'b0;
            next_st.wdt_hold = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Events after clears so a coincident edge is kept
    if (ev_ext)   next_st.st_ext = 1'b1; // R2
    if (ev_ldac)  next_st.st_ldac = 1'b1; // R3
    if (ev_start) next_st.st_start = 1'b1; // R4
    if (ev_trig)  next_st.st_trig = 1'b1; // R5

    if (st.wdt_fire)
    begin
      next_st.ctrl = DCW_RESET_WORD; // R9
      next_st.wdt_load = DCW_RESET_WORD;
      next_st.wdt_count = DCW_RESET_WORD;
      next_st.dout = 16'h0000;
      next_st.irq_en = 8'h00;
      next_st.st_ext = 1'b0;
      next_st.st_ldac = 1'b0;
      next_st.st_start = 1'b0;
      next_st.st_trig = 1'b0;
      next_st.wdg_flag = 1'b1; // R11
      next_st.wdt_hold = st.wdt_hold | st.ctrl[DCW_WDT_EN]; // R10
    end

    if (reg_rd)
    begin
      next_st.rvalid = 1'b1;
      unique case (reg_addr)
        DCW_OFS_CTRL: next_st.rdata = st.ctrl;
        DCW_OFS_WDT:  next_st.rdata = st.wdt_load;
        DCW_OFS_DATA: next_st.rdata = {16'h0000, (st.dout & dir_mask) | (st.sync2 & ~dir_mask)};
        DCW_OFS_IRQ:  next_st.rdata = {st.wdg_flag, 7'h00, st.st_ext, st.st_ldac, 4'h0,
                                       st.st_start, st.st_trig, 8'h00, st.irq_en};
        default:      next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  always_comb
  begin
    dio_oe = dir_mask; // R7
    dio_out = st.dout; // R14
    // Pin 11 reads high while armed, low once the dog has barked
    if (st.ctrl[DCW_WDT_EN] || st.wdt_hold)
    begin
      dio_oe[DCW_PIN_WDT] = 1'b1; // R1
      dio_out[DCW_PIN_WDT] = ~st.wdt_hold; // R10
    end
  end

  assign reg_rdata = st.rdata;
  assign reg_rvalid = st.rvalid;
  assign dac_load = ev_ldac; // R3
  assign converter_start = ev_start; // R4
  assign converter_trigger = ev_trig; // R5
  assign board_reset = st.wdt_fire; // R9
  assign irq_request = (st.st_ext & st.irq_en[DCW_IE_EXT]) | (st.st_ldac & st.irq_en[DCW_IE_LDAC])
                     | (st.st_start & st.irq_en[DCW_IE_START]) | (st.st_trig & st.irq_en[DCW_IE_TRIG]);

  property p_wdt_off;
    @(posedge mclk) disable iff (rst) (st.wdt_load == 32'h0000_0000) |=> !board_reset;
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("watchdog fired while disabled"); // R12

  property p_wdt_expire;
    @(posedge mclk) disable iff (rst)
      (st.wdt_load != 32'h0000_0000 && st.wdt_count == 32'h0000_0001 && adc_tick && !reg_wr && !st.wdt_fire)
      |=> board_reset;
  endproperty
  a_wdt_expire: assert property (p_wdt_expire) else $error("watchdog did not time out"); // R8

  property p_wdt_reload;
    @(posedge mclk) disable iff (rst)
      (reg_wr && reg_addr == DCW_OFS_WDT && reg_wdata > 32'h0000_0001 && !st.wdt_fire) |=> !board_reset ##1 !board_reset;
  endproperty
  a_wdt_reload: assert property (p_wdt_reload) else $error("reload did not restart countdown"); // R17

  property p_board_clear;
    @(posedge mclk) disable iff (rst)
      board_reset |=> (st.ctrl == 32'h0000_0000 && st.wdt_load == 32'h0000_0000 && st.wdg_flag);
  endproperty
  a_board_clear: assert property (p_board_clear) else $error("board reset incomplete"); // R9
  property p_flag_latch;
    @(posedge mclk) disable iff (rst) $rose(board_reset) |=> st.wdg_flag ##1
      (st.wdg_flag || $past(reg_wr && reg_addr == DCW_OFS_IRQ && reg_wdata[DCW_ST_WDG]));
  endproperty
  a_flag_latch: assert property (p_flag_latch) else $error("watchdog flag lost"); // R11
  property p_pin_hold;
    @(posedge mclk) disable iff (rst)
      (board_reset && st.ctrl[DCW_WDT_EN]) |=> (dio_oe[DCW_PIN_WDT] && !dio_out[DCW_PIN_WDT]);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("status pin not driven low"); // R10

  property p_wdt_pin;
    @(posedge mclk) disable iff (rst) st.ctrl[DCW_WDT_EN] |-> dio_oe[DCW_PIN_WDT];
  endproperty
  a_wdt_pin: assert property (p_wdt_pin) else $error("status pin not an output"); // R1
  property p_group0;
    @(posedge mclk) disable iff (rst) (reg_wr && reg_addr == DCW_OFS_CTRL && !st.wdt_fire)
      |=> (dio_oe[7:0] == {8{$past(reg_wdata[DCW_GRP0_BIT])}});
  endproperty
  a_group0: assert property (p_group0) else $error("group 0 direction wrong"); // R7

  property p_data_out;
    @(posedge mclk) disable iff (rst) (reg_wr && reg_addr == DCW_OFS_DATA && !st.wdt_fire)
      |=> (dio_out[7:0] == $past(reg_wdata[7:0]));
  endproperty
  a_data_out: assert property (p_data_out) else $error("output level not written"); // R14

  property p_ldac_irq;
    @(posedge mclk) disable iff (rst) (ev_ldac && !st.wdt_fire) |=> st.st_ldac;
  endproperty
  a_ldac_irq: assert property (p_ldac_irq) else $error("load event not latched"); // R3

  property p_w1c;
    @(posedge mclk) disable iff (rst)
      (reg_wr && reg_addr == DCW_OFS_IRQ && reg_wdata[DCW_ST_EXT] && !ev_ext) |=> !st.st_ext;
  endproperty
  a_w1c: assert property (p_w1c) else $error("status bit not cleared"); // R15
endmodule
`default_nettype wire

// ---- rtl/dcw_pkg.sv ----
// Constants shared by the digital I/O control and watchdog block
package dcw_pkg;
  localparam logic [7:0]  DCW_OFS_IRQ      = 8'h40;
  localparam logic [7:0]  DCW_OFS_DATA     = 8'h44;
  localparam logic [7:0]  DCW_OFS_CTRL     = 8'h48;
  localparam logic [7:0]  DCW_OFS_WDT      = 8'h4C;
  localparam int          DCW_PINS         = 16;
  localparam int          DCW_GROUPS       = 9;
  localparam int          DCW_GRP_LSB      = 8;
  localparam int          DCW_GRP0_BIT     = 0;
  localparam int          DCW_TRIG_EN      = 16;
  localparam int          DCW_TRIG_EDGE    = 17;
  localparam int          DCW_START_EN     = 18;
  localparam int          DCW_START_EDGE   = 19;
  localparam int          DCW_LDAC_EN      = 20;
  localparam int          DCW_LDAC_EDGE    = 21;
  localparam int          DCW_EXT_EN       = 22;
  localparam int          DCW_EXT_EDGE     = 23;
  localparam int          DCW_WDT_EN       = 24;
  localparam int          DCW_PIN_WDT      = 11;
  localparam int          DCW_PIN_LDAC     = 12;
  localparam int          DCW_PIN_EXT      = 13;
  localparam int          DCW_PIN_START    = 14;
  localparam int          DCW_PIN_TRIG     = 15;
  localparam int          DCW_ST_TRIG      = 16;
  localparam int          DCW_ST_START     = 17;
  localparam int          DCW_ST_LDAC      = 22;
  localparam int          DCW_ST_EXT       = 23;
  localparam int          DCW_ST_WDG       = 31;
  localparam int          DCW_IE_TRIG      = 0;
  localparam int          DCW_IE_START     = 1;
  localparam int          DCW_IE_LDAC      = 6;
  localparam int          DCW_IE_EXT       = 7;
  localparam logic [31:0] DCW_CTRL_MASK    = 32'h01FF_FF01;
  localparam logic [7:0]  DCW_IE_MASK      = 8'hC3;
  localparam logic [31:0] DCW_RESET_WORD   = 32'h0000_0000;
endpackage

// ---- rtl/dcw_edge.sv ----
// Selectable edge detector for one digital input secondary function
`timescale 1ns/1ps
`default_nettype none
module dcw_edge
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic level,
  input  wire logic enable,
  input  wire logic rising_sel,
  output logic      pulse
);
  typedef struct packed
  {
    logic prev;
    logic pulse;
  } dcw_edge_state_t;

  dcw_edge_state_t st;
  dcw_edge_state_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.prev = level;
    // Set selects rising, clear selects falling
    next_st.pulse = enable & (rising_sel ? (level & ~st.prev) : (~level & st.prev)); // R6
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign pulse = st.pulse;
endmodule
`default_nettype wire

// ---- dv/dcw_pin_model.sv ----
// Field side of the digital pins: external drivers merged with the block's drivers
`timescale 1ns/1ps
`default_nettype none
module dcw_pin_model
(
  input  wire logic [15:0] ext_level,
  input  wire logic [15:0] dio_out,
  input  wire logic [15:0] dio_oe,
  output logic      [15:0] dio_in
);
  // Board drive wins where enabled, so readback shows the commanded level
  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      dio_in[i] = dio_oe[i] ? dio_out[i] : ext_level[i];
    end
  end
endmodule
`default_nettype wire

// ---- dv/dcw_top_test.sv ----
// Register-level testbench of the digital I/O control and watchdog block
`timescale 1ns/1ps
`default_nettype none
module dcw_top_test;
  import dcw_pkg::*;
  logic        mclk, rst, reg_wr, reg_rd, reg_rvalid, adc_tick;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] ext_level, dio_in, dio_out, dio_oe;
  logic        dac_load, converter_start, converter_trigger, irq_request, board_reset;
  int          fail_count, n_tests, rcnt;
  int          pc[4];
  localparam int PIN[4] = '{DCW_PIN_EXT, DCW_PIN_LDAC, DCW_PIN_START, DCW_PIN_TRIG};
  localparam int EN[4]  = '{DCW_EXT_EN, DCW_LDAC_EN, DCW_START_EN, DCW_TRIG_EN};
  localparam int EDG[4] = '{DCW_EXT_EDGE, DCW_LDAC_EDGE, DCW_START_EDGE, DCW_TRIG_EDGE};
  localparam int ST[4]  = '{DCW_ST_EXT, DCW_ST_LDAC, DCW_ST_START, DCW_ST_TRIG};
  localparam int IE[4]  = '{DCW_IE_EXT, DCW_IE_LDAC, DCW_IE_START, DCW_IE_TRIG};
  dcw_top i_dut (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .adc_tick(adc_tick),
    .dio_in(dio_in), .dio_out(dio_out), .dio_oe(dio_oe), .dac_load(dac_load),
    .converter_start(converter_start), .converter_trigger(converter_trigger),
    .irq_request(irq_request), .board_reset(board_reset));
  dcw_pin_model i_pins (.ext_level(ext_level), .dio_out(dio_out), .dio_oe(dio_oe), .dio_in(dio_in));
  always #5 mclk = ~mclk;
  // Pulse tallies; the external interrupt source has no pulse output of its own
  always @(posedge mclk)
  begin
    pc[1] <= pc[1] + int'(dac_load === 1'b1);
    pc[2] <= pc[2] + int'(converter_start === 1'b1);
    pc[3] <= pc[3] + int'(converter_trigger === 1'b1);
    rcnt  <= rcnt + int'(board_reset === 1'b1);
  end
  task automatic final_report();
    if (fail_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Whole-word accesses only; no partial writes exist on this bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge mclk);
    #1 reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge mclk);
    #1 reg_rd = 1'b0;
    chk({31'h0, reg_rvalid}, 32'h1);
    chk(reg_rdata, exp);
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge mclk);
      #1 adc_tick = 1'b1;
      @(posedge mclk);
      #1 adc_tick = 1'b0;
    end
  endtask
  initial
  begin
    #300us;
    fail_count++;
    final_report();
  end
  initial
  begin
    int p0;
    logic sl, ex;
    mclk = 0; rst = 1; reg_wr = 0; reg_rd = 0; reg_addr = 8'h00; reg_wdata = 32'h0;
    adc_tick = 0; ext_level = 16'h0000; rcnt = 0; pc = '{0, 0, 0, 0};
    repeat (20) @(posedge mclk);
    #1 rst = 1'b0;
    foreach (PIN[i]) rd(8'h40 + 8'(4 * i), 32'h0);
    rd(8'h50, 32'h0);
    wr(DCW_OFS_CTRL, 32'hFFFF_FFFF);
    rd(DCW_OFS_CTRL, 32'h01FF_FF01);
    for (int g = 0; g < 9; g++)
    begin
      wr(DCW_OFS_CTRL, (g == 0) ? 32'h1 : 32'h1 << (7 + g));
      cyc(2);
      chk(dio_oe, (g == 0) ? 32'h00FF : 32'h1 << (7 + g));
    end
    wr(DCW_OFS_CTRL, 32'h0000_FF01);
    wr(DCW_OFS_DATA, 32'h0000_A5C3);
    cyc(2);
    chk(dio_out, 32'hA5C3);
    rd(DCW_OFS_DATA, 32'h0000_A5C3);
    wr(DCW_OFS_CTRL, 32'h0);
    // k 0 falling, 1 rising, 2 function off
    for (int s = 0; s < 4; s++)
      for (int k = 0; k < 3; k++)
      begin
        sl = (k == 0);
        ex = (k != 2);
        ext_level[PIN[s]] = sl;
        cyc(6);
        wr(DCW_OFS_CTRL, (32'(ex) << EN[s]) | (32'(k == 1) << EDG[s]));
        wr(DCW_OFS_IRQ, 32'h80C3_0000 | (32'h1 << IE[s]));
        cyc(2);
        p0 = pc[s];
        ext_level[PIN[s]] = ~sl;
        cyc(8);
        rd(DCW_OFS_IRQ, (32'(ex) << ST[s]) | (32'h1 << IE[s]));
        chk({31'h0, irq_request}, 32'(ex));
        if (s > 0) chk(pc[s] - p0, 32'(ex));
        wr(DCW_OFS_IRQ, (32'h1 << ST[s]) | (32'h1 << IE[s]));
        ext_level[PIN[s]] = sl;
        cyc(8);
        rd(DCW_OFS_IRQ, 32'h1 << IE[s]);
        chk({31'h0, irq_request}, 32'h0);
      end
    wr(DCW_OFS_IRQ, 32'h0);
    wr(DCW_OFS_CTRL, 32'h0100_0101);
    cyc(2);
    chk({30'h0, dio_oe[11], dio_out[11]}, 32'h3);
    wr(DCW_OFS_WDT, 32'h3);
    tick(2);
    wr(DCW_OFS_WDT, 32'h3);
    tick(2);
    chk(rcnt, 32'h0);
    tick(1);
    cyc(2);
    chk(rcnt, 32'h1);
    rd(DCW_OFS_CTRL, 32'h0);
    rd(DCW_OFS_WDT, 32'h0);
    chk({30'h0, dio_oe[11], dio_out[11]}, 32'h2);
    rd(DCW_OFS_IRQ, 32'h8000_0000);
    wr(DCW_OFS_IRQ, 32'h8000_0000);
    rd(DCW_OFS_IRQ, 32'h0);
    wr(DCW_OFS_WDT, 32'h2);
    wr(DCW_OFS_WDT, 32'h0);
    tick(5);
    chk(rcnt, 32'h1);
    final_report();
  end
endmodule
`default_nettype wire
